// [shared/fdc_pkg.sv]
// Constants for the floppy disk command port block.
// Assumes a 20 MHz system clock and an 8-bit host I/O port bus.
package fdc_pkg;
	// ----------------------------------------
	// Port addresses (all 8 bits of I/O address)
	// ----------------------------------------
	localparam logic [7:0] PORT_CMD_STAT = 8'hf8;
	localparam logic [7:0] PORT_SECTOR   = 8'hfa;
	localparam logic [7:0] PORT_DATA     = 8'hfb;
	localparam logic [7:0] PORT_WAIT     = 8'hfc;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_STEP_IN  = 8'h43;
	localparam logic [7:0] CMD_STEP_OUT = 8'h63;
	localparam logic [7:0] CMD_SEEK     = 8'h13;
	localparam logic [7:0] CMD_RESTORE  = 8'h03;
	localparam logic [7:0] CMD_READ     = 8'h8c;
	localparam logic [2:0] CMD_TYPE2_RD = 3'h4;

	// ----------------------------------------
	// Geometry and status fields
	// ----------------------------------------
	localparam logic [6:0] TRACK_MAX     = 7'h4c;
	localparam logic [7:0] SECTOR_BYTES  = 8'h80;
	localparam int         ST_BUSY       = 0;
	localparam int         ST_DRQ        = 1;
	localparam int         ST_LOST       = 2;
	localparam int         ST_NOTFOUND   = 4;
	localparam int         ST_NOTREADY   = 7;
	localparam int         WAIT_DONE_BIT = 7;
	localparam int         FIFO_DEPTH    = 4;
	localparam int         FIFO_WIDTH    = 8;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ        = 20_000_000;
	localparam int STEP_RATE_US  = 10_000;
	localparam int STEP_CYCLES   = STEP_RATE_US * (CLK_HZ / 1_000_000);
	localparam int REV_MS        = 200;
	localparam int UNLOAD_REVS   = 2;
	localparam int UNLOAD_CYCLES = UNLOAD_REVS * REV_MS * (CLK_HZ / 1_000);
	localparam int BYTE_US       = 32;
	localparam int BYTE_CYCLES   = BYTE_US * (CLK_HZ / 1_000_000);
	localparam int LOST_CYCLES   = 4 * BYTE_CYCLES;
endpackage

// [hw/fdc_fifo.sv]
// Small synchronous FIFO for sector bytes.
// Assumes one clock; both sides use valid/ready.
`timescale 1ns/100ps
module fdc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge sys_clk) begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [hw/fdc_pace.sv]
// Periodic enable divider with restartable count.
// Assumes one clock; pulse is one cycle wide.
`timescale 1ns/100ps
module fdc_pace #(
	parameter int unsigned PERIOD = 200
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// Control
	input  wire logic run,
	// Tick
	output logic      tick
);
	localparam int W = $clog2(PERIOD + 1);
	logic [W-1:0] cnt_q;

	assign tick = run && (cnt_q == W'(PERIOD - 1));

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			cnt_q <= '0;
		else if (!run || tick)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end
endmodule

// [hw/fdc_cmd_port.sv]
// Command port of a programmed-transfer floppy disk adapter.
// Assumes host I/O strobes synchronous to sys_clk, drive pins sampled directly.
`timescale 1ns/100ps
module fdc_cmd_port #(
	parameter int unsigned STEP_CYCLES   = fdc_pkg::STEP_CYCLES,
	parameter int unsigned UNLOAD_CYCLES = fdc_pkg::UNLOAD_CYCLES,
	parameter int unsigned LOST_CYCLES   = fdc_pkg::LOST_CYCLES
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// Host I/O port
	input  wire logic [7:0] io_addr,
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	output logic            io_wait,
	// Drive pins
	input  wire logic       track0_b,
	input  wire logic       ready_b,
	output logic            step_q,
	output logic            dir_in_q,
	output logic            head_load_q,
	// Disk byte stream
	input  wire logic       disk_valid,
	input  wire logic [7:0] disk_data,
	input  wire logic       disk_sector_found,
	// Sector select to read channel
	output logic      [7:0] sector_q
);
	typedef enum logic [2:0] {ST_IDLE, ST_HOME, ST_STEP, ST_SEEK, ST_READ} fdc_state_t;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] p);
		hit = (a == p);
	endfunction

	fdc_state_t  state_q;
	logic [6:0]  track_q;
	logic [6:0]  target_q;
	logic [7:0]  data_q;
	logic [7:0]  status_q;
	logic [7:0]  byte_cnt_q;
	logic        done_q;
	logic        step_tick;
	logic        unload_tick;
	logic        lost_tick;
	logic        wr_cmd;
	logic        rd_data;
	logic        rd_wait;
	logic        f_valid;
	logic        f_ready;
	logic [7:0]  f_data;
	logic        f_in_ready;
	logic        byte_transfer_request;
	logic        stepping;
	logic        reading;
	logic        rd_cmd;
	logic        disk_take;

	assign wr_cmd   = io_wr && hit(io_addr, fdc_pkg::PORT_CMD_STAT);
	assign rd_data  = io_rd && hit(io_addr, fdc_pkg::PORT_DATA);
	assign rd_wait  = io_rd && hit(io_addr, fdc_pkg::PORT_WAIT);
	assign stepping = (state_q == ST_HOME) || (state_q == ST_STEP) || (state_q == ST_SEEK);
	assign reading  = (state_q == ST_READ);
	assign byte_transfer_request      = f_valid;
	assign rd_cmd   = wr_cmd && (io_wdata[7:5] == fdc_pkg::CMD_TYPE2_RD);
	// Bytes past one sector are never taken
	assign disk_take = reading && disk_valid && (byte_cnt_q != fdc_pkg::SECTOR_BYTES);

	// ------------------------------------------------------------
	// Dividers
	// ------------------------------------------------------------
	fdc_pace #(.PERIOD(STEP_CYCLES)) u_step (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.run     (stepping),
		.tick    (step_tick)
	);

	// Restarted by each read command so a busy host keeps the head down
	// Also runs while reading, bounding the search for a missing sector
	fdc_pace #(.PERIOD(UNLOAD_CYCLES)) u_unload (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.run     ((head_load_q || reading) && !rd_cmd),
		.tick    (unload_tick)
	);

	// Host too slow: a full buffer while the disk keeps turning
	fdc_pace #(.PERIOD(LOST_CYCLES)) u_lost (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.run     (reading && !f_in_ready),
		.tick    (lost_tick)
	);

	// ------------------------------------------------------------
	// Sector byte buffer
	// ------------------------------------------------------------
	fdc_fifo #(.WIDTH(fdc_pkg::FIFO_WIDTH), .DEPTH(fdc_pkg::FIFO_DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.flush     (!reading),
		.in_valid  (disk_take),
		.in_ready  (f_in_ready),
		.in_data   (disk_data),
		.out_valid (f_valid),
		.out_ready (rd_data),
		.out_data  (f_data)
	);

	// ------------------------------------------------------------
	// Host registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			sector_q <= 8'h01;
		else if (io_wr && hit(io_addr, fdc_pkg::PORT_SECTOR))
			sector_q <= io_wdata;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			data_q <= '0;
		else if (io_wr && hit(io_addr, fdc_pkg::PORT_DATA))
			data_q <= io_wdata;
		else if (rd_data && f_valid)
			data_q <= f_data;
	end

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= ST_HOME;
			track_q    <= '0;
			target_q   <= '0;
			byte_cnt_q <= '0;
			status_q   <= '0;
			done_q     <= 1'b0;
			dir_in_q   <= 1'b0;
		end else begin
			if (rd_wait && done_q && !byte_transfer_request)
				done_q <= 1'b0;
			case (state_q)
			ST_HOME: begin
				dir_in_q <= 1'b0;
				if (!track0_b) begin
					track_q  <= '0;
					state_q  <= ST_IDLE;
					done_q   <= 1'b1;
					status_q <= '0;
				end
			end
			ST_STEP, ST_SEEK: begin
				if (track_q == target_q) begin
					state_q <= ST_IDLE;
					done_q  <= 1'b1;
				end else if (step_tick) begin
					track_q <= dir_in_q ? track_q + 1'b1 : track_q - 1'b1;
				end else begin
					dir_in_q <= (target_q > track_q);
				end
			end
			ST_READ: begin
				// Counted even into a full buffer, so a slow host cannot hang the end
				if (disk_take)
					byte_cnt_q <= byte_cnt_q + 1'b1;
				if (lost_tick)
					status_q[fdc_pkg::ST_LOST] <= 1'b1;
				if (ready_b) begin
					status_q[fdc_pkg::ST_NOTREADY] <= 1'b1;
					state_q <= ST_IDLE;
					done_q  <= 1'b1;
				end else if (!disk_sector_found && unload_tick) begin
					status_q[fdc_pkg::ST_NOTFOUND] <= 1'b1;
					state_q <= ST_IDLE;
					done_q  <= 1'b1;
				end else if (byte_cnt_q == fdc_pkg::SECTOR_BYTES && !f_valid) begin
					state_q <= ST_IDLE;
					done_q  <= 1'b1;
				end
			end
			default: begin
				if (wr_cmd) begin
					done_q   <= 1'b0;
					status_q <= '0;
					if (io_wdata == fdc_pkg::CMD_STEP_IN) begin
						target_q <= (track_q == fdc_pkg::TRACK_MAX) ? track_q : track_q + 1'b1;
						state_q  <= ST_STEP;
					end else if (io_wdata == fdc_pkg::CMD_STEP_OUT) begin
						target_q <= (track_q == '0) ? track_q : track_q - 1'b1;
						state_q  <= ST_STEP;
					end else if (io_wdata == fdc_pkg::CMD_SEEK) begin
						target_q <= (data_q[6:0] > fdc_pkg::TRACK_MAX) ?
							fdc_pkg::TRACK_MAX : data_q[6:0];
						state_q  <= ST_SEEK;
					end else if (io_wdata == fdc_pkg::CMD_RESTORE) begin
						state_q <= ST_HOME;
					end else if (io_wdata[7:5] == fdc_pkg::CMD_TYPE2_RD) begin
						byte_cnt_q <= '0;
						state_q    <= ST_READ;
					end else begin
						done_q <= 1'b1;
					end
				end
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Drive outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			step_q <= 1'b0;
		else
			step_q <= step_tick && ((state_q == ST_HOME && track0_b) ||
				((state_q == ST_STEP || state_q == ST_SEEK) && track_q != target_q));
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			head_load_q <= 1'b0;
		else if (wr_cmd && state_q == ST_IDLE && io_wdata == fdc_pkg::CMD_READ)
			head_load_q <= 1'b1;
		else if (unload_tick && !reading)
			head_load_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// Host read mux and wait
	// ------------------------------------------------------------
	assign io_wait = rd_wait && !byte_transfer_request && !done_q;

	always_comb begin
		io_rdata = 8'h00;
		if (hit(io_addr, fdc_pkg::PORT_CMD_STAT))
			io_rdata = {status_q[7:2], byte_transfer_request, (state_q != ST_IDLE)};
		else if (hit(io_addr, fdc_pkg::PORT_DATA))
			io_rdata = f_valid ? f_data : data_q;
		else if (hit(io_addr, fdc_pkg::PORT_SECTOR))
			io_rdata = sector_q;
		else if (hit(io_addr, fdc_pkg::PORT_WAIT))
			io_rdata = {byte_transfer_request, 7'h00};
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_track_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
		track_q <= fdc_pkg::TRACK_MAX) else $error("track beyond inner limit");
	a_home_stops: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(state_q == ST_HOME && !track0_b) |=> !step_q && track_q == '0)
		else $error("stepping after track zero");
	a_wait_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(rd_wait && byte_transfer_request) |-> !io_wait && io_rdata[fdc_pkg::WAIT_DONE_BIT])
		else $error("wait not released by data request");
	a_wait_done_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(rd_wait && !io_wait && !byte_transfer_request) |-> !io_rdata[fdc_pkg::WAIT_DONE_BIT])
		else $error("done wait bit set");
	a_read_loads: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wr_cmd && state_q == ST_IDLE && io_wdata == fdc_pkg::CMD_READ) |=> head_load_q)
		else $error("head not loaded by read");
	a_step_in_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wr_cmd && state_q == ST_IDLE && io_wdata == fdc_pkg::CMD_STEP_IN &&
		track_q != fdc_pkg::TRACK_MAX) |=> ##1 dir_in_q)
		else $error("step in direction wrong");
	a_seek_target: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wr_cmd && state_q == ST_IDLE && io_wdata == fdc_pkg::CMD_SEEK &&
		data_q[6:0] <= fdc_pkg::TRACK_MAX) |=> target_q == $past(data_q[6:0]))
		else $error("seek target not taken");
	a_byte_limit: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reading |-> byte_cnt_q <= fdc_pkg::SECTOR_BYTES)
		else $error("more than one sector of bytes");
	a_notready_fail: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(reading && ready_b) |=> status_q[fdc_pkg::ST_NOTREADY] && done_q)
		else $error("not ready not reported");
	a_lost_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(reading && lost_tick) |=> status_q[fdc_pkg::ST_LOST])
		else $error("lost data not flagged");
	a_notfound_fail: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(reading && !ready_b && !disk_sector_found && unload_tick) |=>
		status_q[fdc_pkg::ST_NOTFOUND] && !reading)
		else $error("missing sector not reported");
	a_head_unload: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(head_load_q && !reading && unload_tick && !wr_cmd) |=> !head_load_q)
		else $error("head held after idle revolutions");
endmodule

// [sim/fdc_drive_model.sv]
// Drive model: stepper carriage, track-zero sensor, ready line, sector byte stream.
// Assumes step_q is a one-cycle pulse with dir_in_q already settled.
`timescale 1ns/100ps
module fdc_drive_model #(
	parameter int START_TRK = 5,
	parameter int GAP       = 5
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// Controller pins
	input  wire logic       step_q,
	input  wire logic       dir_in_q,
	input  wire logic       head_load_q,
	output logic            track0_b,
	output logic            ready_b,
	// Byte stream
	output logic            disk_valid,
	output logic      [7:0] disk_data,
	output logic            disk_sector_found,
	// Bench control and view
	input  wire logic       spin_ok,
	output logic      [6:0] trk
);
	int gap_cnt;
	int idx;

	// Carriage is not reset by the controller, so it starts off home
	initial trk = 7'(START_TRK);
	always @(posedge sys_clk) begin
		if (step_q && dir_in_q && trk < 7'd76) begin
			trk <= trk + 7'd1;
		end else if (step_q && !dir_in_q && trk != 7'd0) begin
			trk <= trk - 7'd1;
		end
	end
	assign track0_b = (trk != 7'd0);
	assign ready_b = !spin_ok;
	assign disk_sector_found = head_load_q && spin_ok;

	// One sector per load; idle data toggles so stale bytes never pass
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_cnt <= 0;
			idx <= 0;
			disk_valid <= 1'b0;
			disk_data <= 8'h00;
		end else begin
			disk_valid <= 1'b0;
			disk_data <= ~disk_data;
			if (!disk_sector_found) begin
				idx <= 0;
				gap_cnt <= 0;
			end else if (idx < 128 && gap_cnt == GAP) begin
				disk_valid <= 1'b1;
				disk_data <= 8'(idx * 3) + 8'ha5;
				idx <= idx + 1;
				gap_cnt <= 0;
			end else begin
				gap_cnt <= gap_cnt + 1;
			end
		end
	end
endmodule

// [sim/fdc_cmd_port_tb.sv]
// Bench for the floppy command port: homing, steps, seeks, sector reads.
// Assumes fdc_drive_model and shortened step and unload counts.
`timescale 1ns/100ps
module fdc_cmd_port_tb;
	logic       sys_clk, rst_b, io_wr, io_rd, spin_ok, io_wait, track0_b, ready_b;
	logic       step_q, dir_in_q, head_load_q, disk_valid, disk_sector_found;
	logic [7:0] io_addr, io_wdata, io_rdata, disk_data, sector_q, rd_b, sec;
	logic [6:0] trk, tgt;
	int         err_total, cmp_count, step_cnt, n, i;
	int         seed = 32'hd975ffcd;

	fdc_cmd_port #(.STEP_CYCLES(4), .UNLOAD_CYCLES(50), .LOST_CYCLES(8)) u_dut (
		.sys_clk, .rst_b, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_wait,
		.track0_b, .ready_b, .step_q, .dir_in_q, .head_load_q, .disk_valid,
		.disk_data, .disk_sector_found, .sector_q);
	fdc_drive_model #(.START_TRK(5), .GAP(5)) u_drive (
		.sys_clk, .rst_b, .step_q, .dir_in_q, .head_load_q, .track0_b, .ready_b,
		.disk_valid, .disk_data, .disk_sector_found, .spin_ok, .trk);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] exp_byte(input int k);
		return 8'(k * 3) + 8'ha5;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge sys_clk);
		io_wr <= 1'b0;
	endtask
	// Data is captured before the taking edge; nothing moves until that edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(negedge sys_clk);
		while (io_wait !== 1'b0 && k < 5000) begin
			@(negedge sys_clk);
			k++;
		end
		if (k == 5000) err_total++;
		d = io_rdata;
		@(posedge sys_clk);
		io_rd <= 1'b0;
	endtask
	task automatic done_wait;
		rd(fdc_pkg::PORT_WAIT, rd_b);
		chk(rd_b, 8'h00, "wait byte");
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(fdc_pkg::PORT_CMD_STAT, c);
		done_wait();
	endtask
	// Wait and data reads until the done request ends the loop
	task automatic drain(output int got_n);
		got_n = 0;
		rd(fdc_pkg::PORT_WAIT, rd_b);
		while (rd_b[7] === 1'b1 && got_n < 200) begin
			rd(fdc_pkg::PORT_DATA, rd_b);
			chk(rd_b, exp_byte(got_n), "sector byte");
			got_n++;
			rd(fdc_pkg::PORT_WAIT, rd_b);
		end
		chk(rd_b, 8'h00, "wait at end");
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, step monitor, watchdog
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (step_q === 1'b1) step_cnt++;
	// Whole run is a few thousand cycles; ten times that is a hang
	initial begin
		repeat (40000) @(posedge sys_clk);
		err_total++;
		report_and_stop();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_addr = 8'h00;
		io_wdata = 8'h00;
		spin_ok = 1'b1;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		done_wait();
		chk({1'b0, trk}, 8'h00, "home track");
		n = step_cnt;
		repeat (40) @(posedge sys_clk);
		chk(8'(step_cnt - n), 8'h00, "steps after home");
		$display("test homing done");

		// Drive not ready: type 1 commands still move the head
		spin_ok <= 1'b0;
		for (i = 0; i < 3; i++) cmd(fdc_pkg::CMD_STEP_IN);
		chk({1'b0, trk}, 8'h03, "step in");
		cmd(fdc_pkg::CMD_STEP_OUT);
		chk({1'b0, trk}, 8'h02, "step out");
		$display("test steps done");

		for (i = 0; i < 6; i++) begin
			tgt = (i == 0) ? 7'd76 : (i == 1) ? 7'd0 : 7'($unsigned($random(seed)) % 77);
			spin_ok <= i[0];
			wr(fdc_pkg::PORT_DATA, {1'b0, tgt});
			cmd(fdc_pkg::CMD_SEEK);
			chk({1'b0, trk}, {1'b0, tgt}, "seek track");
		end
		cmd(fdc_pkg::CMD_RESTORE);
		chk({1'b0, trk}, 8'h00, "restore");
		$display("test seeks done");

		spin_ok <= 1'b1;
		sec = 8'(($unsigned($random(seed)) % 26) + 1);
		wr(fdc_pkg::PORT_SECTOR, sec);
		wr(fdc_pkg::PORT_CMD_STAT, fdc_pkg::CMD_READ);
		repeat (2) @(posedge sys_clk);
		chk({7'h00, head_load_q}, 8'h01, "head load");
		chk(sector_q, sec, "sector reg");
		drain(n);
		chk(8'(n), 8'h80, "byte count");
		rd(fdc_pkg::PORT_CMD_STAT, rd_b);
		chk(rd_b & 8'h94, 8'h00, "status clean");
		repeat (70) @(posedge sys_clk);
		chk({7'h00, head_load_q}, 8'h00, "head unload");
		$display("test read done");

		// Host asleep through a whole sector: buffer keeps its first bytes
		wr(fdc_pkg::PORT_CMD_STAT, fdc_pkg::CMD_READ);
		repeat (850) @(posedge sys_clk);
		rd(fdc_pkg::PORT_CMD_STAT, rd_b);
		chk(rd_b & 8'h97, 8'h07, "busy drq lost");
		drain(n);
		chk(8'(n), 8'(fdc_pkg::FIFO_DEPTH), "bytes kept");
		$display("test lost data done");

		spin_ok <= 1'b0;
		cmd(fdc_pkg::CMD_READ);
		rd(fdc_pkg::PORT_CMD_STAT, rd_b);
		chk(rd_b & 8'h80, 8'h80, "not ready status");
		repeat (70) @(posedge sys_clk);
		chk({7'h00, head_load_q}, 8'h00, "unload after fail");
		// Read without the head-load bit: no sector can be found
		spin_ok <= 1'b1;
		cmd(8'h88);
		chk({7'h00, head_load_q}, 8'h00, "no head load");
		rd(fdc_pkg::PORT_CMD_STAT, rd_b);
		chk(rd_b & 8'h94, 8'h10, "not found status");
		$display("test not ready done");
		report_and_stop();
	end
endmodule
